// ==== src/sde_pkg.sv ====
package sde_pkg;
  // Clock rate of the register and timing logic
  localparam int CLK_MHZ = 10;
  localparam int NS_PER_US = 1000;

  // Register offsets
  localparam logic [7:0] REG_OUT_LEVEL = 8'h83;
  localparam logic [7:0] REG_LOCK_OUT = 8'h84;
  localparam logic [7:0] REG_GAP = 8'h85;
  localparam logic [7:0] REG_BURST_CNT = 8'h86;
  localparam logic [7:0] REG_ADJ_EN = 8'h87;
  localparam logic [7:0] REG_IN_FMT = 8'h88;
  localparam logic [7:0] REG_LIMITER = 8'h89;
  localparam logic [7:0] REG_TIMING = 8'h8a;
  localparam logic [7:0] REG_SYNC_WD = 8'h8b;
  localparam logic [7:0] REG_FSC0 = 8'h8c;
  localparam logic [7:0] REG_FSC1 = 8'h8d;
  localparam logic [7:0] REG_FSC2 = 8'h8e;
  localparam logic [7:0] REG_FSC3 = 8'h8f;
  localparam logic [7:0] REG_PHASE_HI = 8'h90;
  localparam logic [7:0] REG_CC_EVEN_LO = 8'h91;
  localparam logic [7:0] REG_CC_EVEN_HI = 8'h92;
  localparam logic [7:0] REG_CC_ODD_LO = 8'h93;
  localparam logic [7:0] REG_CC_ODD_HI = 8'h94;
  localparam logic [7:0] REG_SETUP_ODD_A = 8'h95;
  localparam logic [7:0] REG_SETUP_ODD_B = 8'h96;
  localparam logic [7:0] REG_SETUP_EVEN_A = 8'h97;
  localparam logic [7:0] REG_SETUP_EVEN_B = 8'h98;
  localparam logic [7:0] REG_CG_CTL = 8'h99;
  localparam logic [7:0] REG_CG_MID = 8'h9a;
  localparam logic [7:0] REG_CG_LOW = 8'h9b;
  localparam logic [7:0] REG_SCALE_LSB = 8'h9c;
  localparam logic [7:0] REG_Y_SCALE = 8'h9d;
  localparam logic [7:0] REG_CB_SCALE = 8'h9e;
  localparam logic [7:0] REG_CR_SCALE = 8'h9f;
  localparam logic [7:0] REG_HUE = 8'ha0;
  localparam logic [7:0] REG_BRIGHT = 8'ha1;
  localparam logic [7:0] REG_BASE = REG_OUT_LEVEL;
  localparam logic [7:0] REG_LAST = REG_BRIGHT;
  localparam int REG_COUNT = 31;

  // Reset values that differ from zero, plus RST_ZERO for all other registers
  localparam logic [7:0] RST_OUT_LEVEL = 8'h04;
  localparam logic [7:0] RST_BURST_CNT = 8'h02;
  localparam logic [7:0] RST_TIMING = 8'h08;
  localparam logic [7:0] RST_FSC0 = 8'h1f;
  localparam logic [7:0] RST_FSC1 = 8'h7c;
  localparam logic [7:0] RST_FSC2 = 8'hf0;
  localparam logic [7:0] RST_FSC3 = 8'h21;
  localparam logic [7:0] RST_ZERO = 8'h00;

  // Writable bit masks; reserved bits keep their reset value
  localparam logic [7:0] MASK_OUT_LEVEL = 8'h7f;
  localparam logic [7:0] MASK_LOCK_OUT = 8'hfe;
  localparam logic [7:0] MASK_BURST_CNT = 8'hcb;
  localparam logic [7:0] MASK_ADJ_EN = 8'hbf;
  localparam logic [7:0] MASK_IN_FMT = 8'hfe;
  localparam logic [7:0] MASK_LIMITER = 8'h33;
  localparam logic [7:0] MASK_TIMING = 8'hf7;
  localparam logic [7:0] MASK_FULL = 8'hff;

  // Field positions
  localparam int B_PEDESTAL = 0;
  localparam int B_LUMA_LVL = 1;
  localparam int F_CHROMA_LVL = 2;
  localparam int B_VBI_OPEN = 4;
  localparam int F_CC_FIELD = 5;
  localparam int F_LOCK_MODE = 1;
  localparam int B_ACT_LEN = 3;
  localparam int B_CHROMA_OFF = 4;
  localparam int B_BURST_OFF = 5;
  localparam int B_COLOR_BARS = 6;
  localparam int B_DAC_SWAP = 7;
  localparam int F_BURST_POS = 0;
  localparam int B_CEA_SYNC = 3;
  localparam int B_CNT_FREE = 6;
  localparam int B_RGB_SWAP = 7;
  localparam int B_SCALE_EN = 0;
  localparam int B_SAT_EN = 1;
  localparam int B_HUE_EN = 2;
  localparam int B_BRIGHT_EN = 3;
  localparam int B_SHAPE_EN = 4;
  localparam int B_AUTODET_EN = 5;
  localparam int B_RGB_IN = 7;
  localparam int B_NONINTERLACE = 1;
  localparam int B_DBL_BUF = 2;
  localparam int F_IN_FMT = 3;
  localparam int B_NOISE_RED = 5;
  localparam int B_GAMMA_EN = 6;
  localparam int B_GAMMA_SEL = 7;
  localparam int F_UNDERSHOOT = 0;
  localparam int F_CHROMA_DLY = 4;
  localparam int B_MASTER = 0;
  localparam int F_TMODE = 1;
  localparam int F_LUMA_DLY = 4;
  localparam int B_MIN_LUMA = 6;
  localparam int B_TIMING_RST = 7;
  localparam int F_HS_WIDTH = 0;
  localparam int F_HV_DELAY = 2;
  localparam int B_VS_EXTRA = 4;
  localparam int F_VS_WIDTH = 4;
  localparam int F_PIX_ADJ = 6;
  localparam int F_Y_LSB = 0;
  localparam int F_CB_LSB = 2;
  localparam int F_CR_LSB = 4;
  localparam int F_PH_LSB = 6;
  localparam int F_CG_HI = 0;
  localparam int B_CG_CRC = 4;
  localparam int B_CG_ODD = 5;
  localparam int B_CG_EVEN = 6;
  localparam int B_WSS_EN = 7;
  localparam int B_WSS_BLANK = 7;

  // Codes
  localparam logic [1:0] TMODE_1 = 2'h1;
  localparam logic [1:0] TMODE_2 = 2'h2;
  localparam logic [1:0] BURST_RESERVED = 2'h3;
  localparam logic [1:0] CHROMA_LVL_STD = 2'h0;

  // Analog levels in mV and active line lengths in pixels
  localparam logic [9:0] LUMA_MV_700 = 10'h2bc;
  localparam logic [9:0] LUMA_MV_714 = 10'h2ca;
  localparam logic [8:0] SYNC_MV_300 = 9'h12c;
  localparam logic [8:0] SYNC_MV_286 = 9'h11e;
  localparam logic [3:0][10:0] CHROMA_MV = {11'h288, 11'h3e8, 11'h2bc,
                                            11'h000};
  localparam logic [10:0] CHROMA_MV_PAL = 11'h2bc;
  localparam logic [10:0] CHROMA_MV_NTSC = 11'h3e8;
  localparam logic [9:0] ACT_PIX_FULL = 10'h2d0;
  localparam logic [9:0] ACT_PIX_NTSC = 10'h2c6;
  localparam logic [9:0] ACT_PIX_PAL = 10'h2be;

  // Burst start delays after horizontal sync, rounded up to cycles
  localparam int BURST_NS_0 = 5170;
  localparam int BURST_NS_1 = 5310;
  localparam int BURST_NS_2 = 5590;
  localparam logic [7:0] BURST_CYC_0 =
    8'((BURST_NS_0 * CLK_MHZ + NS_PER_US - 1) / NS_PER_US);
  localparam logic [7:0] BURST_CYC_1 =
    8'((BURST_NS_1 * CLK_MHZ + NS_PER_US - 1) / NS_PER_US);
  localparam logic [7:0] BURST_CYC_2 =
    8'((BURST_NS_2 * CLK_MHZ + NS_PER_US - 1) / NS_PER_US);

  // Sync widths and delays in clock cycles
  localparam logic [3:0][7:0] SYNC_WIDTHS = {8'h80, 8'h10, 8'h04, 8'h01};
  localparam logic [3:0][7:0] HV_DELAYS = {8'h12, 8'h08, 8'h04, 8'h00};
  localparam int VS_EXTRA_US = 32;
  localparam logic [10:0] VS_EXTRA_CYC = 11'(VS_EXTRA_US * CLK_MHZ);

  localparam int H_W = 11;
  localparam int V_W = 10;

  typedef struct packed {
    logic pedestal_en;
    logic [9:0] luma_video_mv;
    logic [8:0] luma_sync_mv;
    logic [10:0] chroma_diff_mv;
    logic blanking_lines_open;
    logic caption_odd_en;
    logic caption_even_en;
    logic [1:0] lock_mode;
    logic [9:0] active_pixels;
    logic chroma_off;
    logic burst_off;
    logic color_bars;
    logic dac2_chroma;
    logic [7:0] burst_delay_cyc;
    logic cea_sync;
    logic rgb_swap;
    logic scale_en;
    logic sat_en;
    logic hue_en;
    logic bright_en;
    logic luma_shaping_filter_gain_en;
    logic autodetect_en;
    logic rgb_input;
    logic noninterlaced;
    logic double_buffer;
    logic [1:0] input_format;
    logic noise_reduction_en;
    logic [1:0] gamma_curve;
    logic [1:0] undershoot;
    logic [1:0] chroma_delay;
    logic [1:0] luma_delay;
    logic min_luma_high;
    logic [31:0] fsc_freq;
    logic [9:0] fsc_phase;
    logic [9:0] luma_scale;
    logic [9:0] cb_scale;
    logic [9:0] cr_scale;
    logic [7:0] hue;
    logic [6:0] brightness;
    logic widescreen_signal_blank;
    logic [15:0] caption_even_data;
    logic [15:0] caption_odd_data;
    logic [15:0] setup_mask_odd;
    logic [15:0] setup_mask_even;
    logic [19:0] copy_generation_data;
    logic copy_gen_crc;
    logic copy_gen_odd;
    logic copy_gen_even;
    logic widescreen_signal_en;
  } sde_cfg_t;

  typedef struct packed {
    logic hsync;
    logic vsync;
    logic field;
    logic [H_W-1:0] h_count;
    logic [V_W-1:0] v_count;
  } sde_sync_t;
endpackage

// ==== src/sde_control_regs.sv ====
module sde_control_regs #(
  parameter int PIX_W = 10,
  parameter int H_TOTAL_NTSC = 858,
  parameter int H_TOTAL_PAL = 864,
  parameter int V_TOTAL_NTSC = 525,
  parameter int V_TOTAL_PAL = 625
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // Register port from the serial control interface
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  // Standard and external sync
  input wire logic pal_mode_in,
  input wire logic ext_hsync_in,
  input wire logic ext_vsync_in,
  // Pixel path
  input wire logic [PIX_W-1:0] pixel_in,
  output logic [PIX_W-1:0] pixel_out,
  // Decoded configuration and timing
  output sde_pkg::sde_cfg_t cfg_out,
  output sde_pkg::sde_sync_t sync_out
);
  import sde_pkg::*;

  logic [7:0] regs [REG_COUNT];
  sde_cfg_t next_cfg;
  sde_sync_t next_sync;
  logic timing_bit_prev;
  logic timing_reset;
  logic hs_meta, hs_sync, hs_prev;
  logic vs_meta, vs_sync, vs_prev;
  logic hs_edge, vs_edge;
  logic [H_W-1:0] h_count;
  logic [V_W-1:0] v_count;
  logic field;
  logic [H_W-1:0] h_last;
  logic [V_W-1:0] v_last;
  logic master, free_run;
  logic [H_W-1:0] hs_width, vs_start, vs_width;
  logic [1:0] tmode;
  logic [PIX_W-1:0] pix_dly [4];
  logic [7:0] timing_reg, sync_reg, burst_reg;

  function automatic logic is_mapped(input logic [7:0] a);
    return (a >= REG_BASE) && (a <= REG_LAST) && (a != REG_GAP);
  endfunction

  function automatic logic [4:0] ri(input logic [7:0] a);
    return 5'(a - REG_BASE);
  endfunction

  function automatic logic [7:0] reset_of(input logic [7:0] a);
    unique case (a)
      REG_OUT_LEVEL: return RST_OUT_LEVEL;
      REG_BURST_CNT: return RST_BURST_CNT;
      REG_TIMING: return RST_TIMING;
      REG_FSC0: return RST_FSC0;
      REG_FSC1: return RST_FSC1;
      REG_FSC2: return RST_FSC2;
      REG_FSC3: return RST_FSC3;
      default: return RST_ZERO;
    endcase
  endfunction

  function automatic logic [7:0] mask_of(input logic [7:0] a);
    unique case (a)
      REG_OUT_LEVEL: return MASK_OUT_LEVEL;
      REG_LOCK_OUT: return MASK_LOCK_OUT;
      REG_BURST_CNT: return MASK_BURST_CNT;
      REG_ADJ_EN: return MASK_ADJ_EN;
      REG_IN_FMT: return MASK_IN_FMT;
      REG_LIMITER: return MASK_LIMITER;
      REG_TIMING: return MASK_TIMING;
      default: return MASK_FULL;
    endcase
  endfunction

  function automatic logic [7:0] rd(input logic [7:0] a);
    return regs[ri(a)];
  endfunction

  // Register writes; reserved bits hold their reset value
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs[i] <= reset_of(8'(int'(REG_BASE) + i));
      end
    end else if (reg_wr_in && is_mapped(reg_addr_in)) begin
      regs[ri(reg_addr_in)] <=
        (reg_wdata_in & mask_of(reg_addr_in)) |
        (regs[ri(reg_addr_in)] & ~mask_of(reg_addr_in));
    end
  end

  // Register reads, answered one cycle later
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= 8'h00;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_rd_in;
      if (reg_rd_in) begin
        reg_rdata_out <= is_mapped(reg_addr_in) ? regs[ri(reg_addr_in)]
                                                : 8'h00;
      end
    end
  end

  // Decode of configuration fields
  always_comb begin
    logic [7:0] r83, r84, r86, r87, r88, r89, r8a, r9c, r99, ra1;
    r83 = rd(REG_OUT_LEVEL);
    r84 = rd(REG_LOCK_OUT);
    r86 = rd(REG_BURST_CNT);
    r87 = rd(REG_ADJ_EN);
    r88 = rd(REG_IN_FMT);
    r89 = rd(REG_LIMITER);
    r8a = rd(REG_TIMING);
    r9c = rd(REG_SCALE_LSB);
    r99 = rd(REG_CG_CTL);
    ra1 = rd(REG_BRIGHT);
    next_cfg = '0;
    next_cfg.pedestal_en = r83[B_PEDESTAL];
    next_cfg.luma_video_mv = r83[B_LUMA_LVL] ? LUMA_MV_714
                                             : LUMA_MV_700;
    next_cfg.luma_sync_mv = r83[B_LUMA_LVL] ? SYNC_MV_286 : SYNC_MV_300;
    if (r83[F_CHROMA_LVL +: 2] == CHROMA_LVL_STD) begin
      next_cfg.chroma_diff_mv = pal_mode_in ? CHROMA_MV_PAL
                                            : CHROMA_MV_NTSC;
    end else begin
      next_cfg.chroma_diff_mv = CHROMA_MV[r83[F_CHROMA_LVL +: 2]];
    end
    next_cfg.blanking_lines_open = r83[B_VBI_OPEN];
    next_cfg.caption_odd_en = r83[F_CC_FIELD];
    next_cfg.caption_even_en = r83[F_CC_FIELD + 1];
    next_cfg.lock_mode = r84[F_LOCK_MODE +: 2];
    if (!r84[B_ACT_LEN]) begin
      next_cfg.active_pixels = ACT_PIX_FULL;
    end else begin
      next_cfg.active_pixels = pal_mode_in ? ACT_PIX_PAL : ACT_PIX_NTSC;
    end
    next_cfg.chroma_off = r84[B_CHROMA_OFF];
    next_cfg.burst_off = r84[B_BURST_OFF];
    next_cfg.color_bars = r84[B_COLOR_BARS];
    next_cfg.dac2_chroma = r84[B_DAC_SWAP];
    unique case (r86[F_BURST_POS +: 2])
      2'h0: next_cfg.burst_delay_cyc = BURST_CYC_0;
      2'h1: next_cfg.burst_delay_cyc = BURST_CYC_1;
      default: next_cfg.burst_delay_cyc = BURST_CYC_2;
    endcase
    next_cfg.cea_sync = r86[B_CEA_SYNC];
    next_cfg.rgb_swap = r86[B_RGB_SWAP];
    next_cfg.scale_en = r87[B_SCALE_EN];
    next_cfg.sat_en = r87[B_SAT_EN];
    next_cfg.hue_en = r87[B_HUE_EN];
    next_cfg.bright_en = r87[B_BRIGHT_EN];
    next_cfg.luma_shaping_filter_gain_en = r87[B_SHAPE_EN];
    next_cfg.autodetect_en = r87[B_AUTODET_EN];
    next_cfg.rgb_input = r87[B_RGB_IN];
    next_cfg.noninterlaced = r88[B_NONINTERLACE];
    next_cfg.double_buffer = r88[B_DBL_BUF];
    next_cfg.input_format = r88[F_IN_FMT +: 2];
    next_cfg.noise_reduction_en = r88[B_NOISE_RED];
    // 0 off, 1 first curve, 2 second curve
    next_cfg.gamma_curve = !r88[B_GAMMA_EN] ? 2'h0 :
                           (r88[B_GAMMA_SEL] ? 2'h2 : 2'h1);
    next_cfg.undershoot = r89[F_UNDERSHOOT +: 2];
    next_cfg.chroma_delay = r89[F_CHROMA_DLY +: 2];
    next_cfg.luma_delay = r8a[F_LUMA_DLY +: 2];
    next_cfg.min_luma_high = r8a[B_MIN_LUMA];
    next_cfg.fsc_freq = {rd(REG_FSC3), rd(REG_FSC2), rd(REG_FSC1),
                         rd(REG_FSC0)};
    next_cfg.fsc_phase = {rd(REG_PHASE_HI), r9c[F_PH_LSB +: 2]};
    next_cfg.luma_scale = {rd(REG_Y_SCALE), r9c[F_Y_LSB +: 2]};
    next_cfg.cb_scale = {rd(REG_CB_SCALE), r9c[F_CB_LSB +: 2]};
    next_cfg.cr_scale = {rd(REG_CR_SCALE), r9c[F_CR_LSB +: 2]};
    next_cfg.hue = rd(REG_HUE);
    next_cfg.brightness = ra1[6:0];
    next_cfg.widescreen_signal_blank = ra1[B_WSS_BLANK];
    next_cfg.caption_even_data = {rd(REG_CC_EVEN_HI), rd(REG_CC_EVEN_LO)};
    next_cfg.caption_odd_data = {rd(REG_CC_ODD_HI), rd(REG_CC_ODD_LO)};
    next_cfg.setup_mask_odd = {rd(REG_SETUP_ODD_B), rd(REG_SETUP_ODD_A)};
    next_cfg.setup_mask_even = {rd(REG_SETUP_EVEN_B),
                                rd(REG_SETUP_EVEN_A)};
    next_cfg.copy_generation_data = {r99[F_CG_HI +: 4], rd(REG_CG_MID),
                                     rd(REG_CG_LOW)};
    next_cfg.copy_gen_crc = r99[B_CG_CRC];
    next_cfg.copy_gen_odd = r99[B_CG_ODD];
    next_cfg.copy_gen_even = r99[B_CG_EVEN];
    next_cfg.widescreen_signal_en = r99[B_WSS_EN];
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      cfg_out <= '0;
    end else begin
      cfg_out <= next_cfg;
    end
  end

  // Control registers read by the timing logic
  assign timing_reg = rd(REG_TIMING);
  assign sync_reg = rd(REG_SYNC_WD);
  assign burst_reg = rd(REG_BURST_CNT);

  // Stored bit falling after a rise marks a low-high-low sequence
  assign timing_reset = timing_bit_prev &
                        ~timing_reg[B_TIMING_RST];

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      timing_bit_prev <= 1'b0;
    end else begin
      timing_bit_prev <= timing_reg[B_TIMING_RST];
    end
  end

  // External sync synchronisers
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      hs_meta <= 1'b0;
      hs_sync <= 1'b0;
      hs_prev <= 1'b0;
      vs_meta <= 1'b0;
      vs_sync <= 1'b0;
      vs_prev <= 1'b0;
    end else begin
      hs_meta <= ext_hsync_in;
      hs_sync <= hs_meta;
      hs_prev <= hs_sync;
      vs_meta <= ext_vsync_in;
      vs_sync <= vs_meta;
      vs_prev <= vs_sync;
    end
  end

  assign hs_edge = hs_sync & ~hs_prev;
  assign vs_edge = vs_sync & ~vs_prev;
  assign free_run = burst_reg[B_CNT_FREE];
  assign h_last = pal_mode_in ? H_W'(H_TOTAL_PAL - 1) : H_W'(H_TOTAL_NTSC - 1);
  assign v_last = pal_mode_in ? V_W'(V_TOTAL_PAL - 1) : V_W'(V_TOTAL_NTSC - 1);

  // Line and field counters
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in || timing_reset) begin
      h_count <= '0;
      v_count <= '0;
      field <= 1'b0;
    end else if (free_run) begin
      h_count <= hs_edge ? '0 : h_count + 1'b1;
      if (vs_edge) begin
        v_count <= '0;
        field <= ~field;
      end else if (hs_edge) begin
        v_count <= v_count + 1'b1;
      end
    end else if (h_count >= h_last) begin
      h_count <= '0;
      if (v_count >= v_last) begin
        v_count <= '0;
        field <= ~field;
      end else begin
        v_count <= v_count + 1'b1;
      end
    end else begin
      h_count <= h_count + 1'b1;
    end
  end

  // Master-mode sync generation
  assign master = timing_reg[B_MASTER];
  assign tmode = timing_reg[F_TMODE +: 2];
  assign hs_width = H_W'(SYNC_WIDTHS[sync_reg[F_HS_WIDTH +: 2]]);
  assign vs_start = H_W'(HV_DELAYS[sync_reg[F_HV_DELAY +: 2]]) +
                    ((tmode == TMODE_1 && sync_reg[B_VS_EXTRA]) ?
                     VS_EXTRA_CYC : '0);
  assign vs_width = (tmode == TMODE_2) ?
                    H_W'(SYNC_WIDTHS[sync_reg[F_VS_WIDTH +: 2]]) :
                    hs_width;

  always_comb begin
    next_sync.h_count = h_count;
    next_sync.v_count = v_count;
    next_sync.field = field;
    next_sync.hsync = master && (h_count < hs_width);
    next_sync.vsync = master && (v_count == '0) &&
                      (h_count >= vs_start) &&
                      (h_count < vs_start + vs_width);
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      sync_out <= '0;
    end else begin
      sync_out <= next_sync;
    end
  end

  // Pixel shift relative to horizontal sync
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < 4; i++) begin
        pix_dly[i] <= '0;
      end
      pixel_out <= '0;
    end else begin
      pix_dly[0] <= pixel_in;
      for (int i = 1; i < 4; i++) begin
        pix_dly[i] <= pix_dly[i-1];
      end
      pixel_out <= pix_dly[sync_reg[F_PIX_ADJ +: 2]];
    end
  end
endmodule // sde_control_regs

// ==== test/sde_control_regs_sva.sv ====
module sde_control_regs_sva
  import sde_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // Register port
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  // Decoded outputs
  input wire sde_pkg::sde_cfg_t cfg_out,
  input wire sde_pkg::sde_sync_t sync_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  logic w83, w84, w86, w9c, adj_any;
  assign w83 = reg_wr_in && reg_addr_in == REG_OUT_LEVEL;
  assign w84 = reg_wr_in && reg_addr_in == REG_LOCK_OUT;
  assign w86 = reg_wr_in && reg_addr_in == REG_BURST_CNT;
  assign w9c = reg_wr_in && reg_addr_in == REG_SCALE_LSB;
  assign adj_any = cfg_out.scale_en || cfg_out.sat_en || cfg_out.hue_en ||
    cfg_out.bright_en || cfg_out.luma_shaping_filter_gain_en ||
    cfg_out.autodetect_en;

  AST_PEDESTAL: assert property (
    w83 |=> ##1 cfg_out.pedestal_en == $past(reg_wdata_in[0], 2))
    else $error("pedestal decode wrong");
  AST_LUMA_LEVEL: assert property (
    w83 |=> ##1 cfg_out.luma_sync_mv ==
      ($past(reg_wdata_in[1], 2) ? 9'h11e : 9'h12c))
    else $error("luma sync level wrong");
  AST_CAPTION: assert property (
    w83 |=> ##1 {cfg_out.caption_even_en, cfg_out.caption_odd_en} ==
      $past(reg_wdata_in[6:5], 2))
    else $error("caption field decode wrong");
  AST_LOCK_MODE: assert property (
    w84 |=> ##1 cfg_out.lock_mode == $past(reg_wdata_in[2:1], 2))
    else $error("lock mode decode wrong");
  AST_SWAP: assert property (
    w84 |=> ##1 {cfg_out.dac2_chroma, cfg_out.burst_off, cfg_out.chroma_off}
      == $past({reg_wdata_in[7], reg_wdata_in[5:4]}, 2))
    else $error("swap or disable bits wrong");
  AST_BURST_POS: assert property (
    w86 |=> ##1 cfg_out.burst_delay_cyc ==
      ($past(reg_wdata_in[1:0], 2) == 2'h0 ? 8'h34 :
       $past(reg_wdata_in[1:0], 2) == 2'h1 ? 8'h36 : 8'h38))
    else $error("burst delay wrong");
  AST_RESET_FSC: assert property (
    $fell(sys_rst_in) |=> cfg_out.fsc_freq == 32'h21f07c1f)
    else $error("subcarrier reset value wrong");
  AST_RESET_ADJ: assert property (
    $fell(sys_rst_in) |=> !adj_any)
    else $error("adjust enables not clear after reset");
  AST_SCALE_LSB: assert property (
    w9c |=> ##1 {cfg_out.fsc_phase[1:0], cfg_out.cr_scale[1:0],
      cfg_out.cb_scale[1:0], cfg_out.luma_scale[1:0]} ==
      $past(reg_wdata_in, 2))
    else $error("low scale bits wrong");

  cover property (w83);
  cover property (w9c);
  cover property (sync_out.hsync);
endmodule // sde_control_regs_sva

bind sde_control_regs sde_control_regs_sva u_sva (.sys_clk_in, .sys_rst_in,
  .reg_wr_in, .reg_addr_in, .reg_wdata_in, .cfg_out, .sync_out);

// ==== test/sde_control_regs_tb.sv ====
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin \
  $display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); fails++; end end

module sde_control_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import sde_pkg::*;
  localparam logic [10:0] CHV [4] = '{11'h3e8, 11'h2bc, 11'h3e8, 11'h288};
  localparam logic [7:0] BCY [4] = '{8'h34, 8'h36, 8'h38, 8'h38};
  localparam int WID [5] = '{1, 4, 16, 128, 0};
  logic sys_clk_in, sys_rst_in, reg_wr_in, reg_rd_in, pal_mode_in;
  logic ext_hsync_in, ext_vsync_in, reg_rvalid_out;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
  logic [9:0] pixel_in, pixel_out;
  logic [1:0] c;
  sde_cfg_t cfg_out;
  sde_sync_t sync_out;
  int fails, num_checks, n, mx;

  sde_control_regs uut (.sys_clk_in, .sys_rst_in, .reg_wr_in, .reg_rd_in,
    .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .reg_rvalid_out,
    .pal_mode_in, .ext_hsync_in, .ext_vsync_in, .pixel_in, .pixel_out,
    .cfg_out, .sync_out);

  initial begin
    sys_clk_in = 1'b0;
    forever #50 sys_clk_in = ~sys_clk_in;
  end
  always @(negedge sys_clk_in) pixel_in <= pixel_in + 10'h001;

  function automatic logic [7:0] rstv(input logic [7:0] a);
    case (a)
      REG_OUT_LEVEL: return 8'h04;
      REG_BURST_CNT: return 8'h02;
      REG_TIMING: return 8'h08;
      REG_FSC0: return 8'h1f;
      REG_FSC1: return 8'h7c;
      REG_FSC2: return 8'hf0;
      REG_FSC3: return 8'h21;
      default: return 8'h00;
    endcase
  endfunction

  task automatic tick(input int k);
    repeat (k) @(negedge sys_clk_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr_in = 1'b1;
    reg_addr_in = a;
    reg_wdata_in = d;
    tick(1);
    reg_wr_in = 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_rd_in = 1'b1;
    reg_addr_in = a;
    tick(1);
    reg_rd_in = 1'b0;
    `CHK(reg_rvalid_out, 1'b1)
    `CHK(reg_rdata_out, e)
    tick(1);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #3000000;
    fails++;
    end_sim();
  end

  initial begin
    {reg_wr_in, reg_rd_in, pal_mode_in, ext_hsync_in, ext_vsync_in} = 5'h00;
    {reg_addr_in, reg_wdata_in} = 16'h0000;
    pixel_in = 10'h000;
    fails = 0;
    num_checks = 0;
    sys_rst_in = 1'b1;
    tick(6);
    sys_rst_in = 1'b0;
    tick(1);
    for (int a = 'h83; a <= 'ha1; a++) rd(8'(a), rstv(8'(a)));
    `CHK(cfg_out.fsc_freq, 32'h21f07c1f)
    $display("reset values done");
    for (int a = 'h8c; a <= 'ha1; a++) wr(8'(a), 8'ha5);
    wr(REG_GAP, 8'hff);
    for (int a = 'h8c; a <= 'ha1; a++) rd(8'(a), 8'ha5);
    rd(REG_GAP, 8'h00);
    `CHK(cfg_out.fsc_freq, 32'ha5a5a5a5)
    `CHK(cfg_out.fsc_phase, 10'h296)
    `CHK(cfg_out.cb_scale, 10'h295)
    $display("data registers done");
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      wr(REG_OUT_LEVEL, {1'b0, c, c[0], c, c[1], c[0]});
      wr(REG_LOCK_OUT, {c[1], c[0], c[1], c[0], c[0], c, 1'b0});
      wr(REG_BURST_CNT, {6'h00, c});
      wr(REG_IN_FMT, {c[1], c[0], 1'b0, c, 3'h0});
      wr(REG_ADJ_EN, (c == 2'h3) ? 8'h3f : 8'h00);
      `CHK(cfg_out.pedestal_en, c[0])
      `CHK(cfg_out.luma_video_mv, c[1] ? 10'h2ca : 10'h2bc)
      `CHK(cfg_out.chroma_diff_mv, CHV[i])
      `CHK(cfg_out.blanking_lines_open, c[0])
      `CHK(({cfg_out.caption_even_en, cfg_out.caption_odd_en}), c)
      `CHK(cfg_out.lock_mode, c)
      `CHK(cfg_out.active_pixels, c[0] ? 10'h2c6 : 10'h2d0)
      `CHK(({cfg_out.dac2_chroma, cfg_out.chroma_off}), c)
      `CHK(cfg_out.burst_delay_cyc, BCY[i])
      `CHK(cfg_out.input_format, c)
      `CHK(cfg_out.gamma_curve, c[0] ? {c[1], ~c[1]} : 2'h0)
      `CHK(cfg_out.hue_en, &c)
    end
    pal_mode_in = 1'b1;
    wr(REG_OUT_LEVEL, 8'h00);
    wr(REG_LOCK_OUT, 8'h08);
    `CHK(cfg_out.chroma_diff_mv, 11'h2bc)
    `CHK(cfg_out.active_pixels, 10'h2be)
    pal_mode_in = 1'b0;
    $display("field decode done");
    wr(REG_TIMING, 8'h01);
    rd(REG_TIMING, 8'h09);
    for (int i = 0; i < 5; i++) begin
      if (i == 4) wr(REG_TIMING, 8'h00);
      else wr(REG_SYNC_WD, 8'(i));
      n = 0;
      mx = 0;
      repeat (858) begin
        tick(1);
        n += int'(sync_out.hsync);
        if (int'(sync_out.h_count) > mx) mx = int'(sync_out.h_count);
      end
      `CHK(n, WID[i])
    end
    `CHK(mx, 857)
    wr(REG_TIMING, 8'h81);
    wr(REG_TIMING, 8'h01);
    tick(1);
    `CHK(sync_out.h_count < 11'h004, 1'b1)
    wr(REG_BURST_CNT, 8'h42);
    {ext_hsync_in, ext_vsync_in} = 2'h3;
    tick(2);
    {ext_hsync_in, ext_vsync_in} = 2'h0;
    tick(4);
    `CHK(sync_out.h_count < 11'h008, 1'b1)
    `CHK(({sync_out.field, sync_out.v_count}), 11'h400)
    tick(900);
    `CHK(sync_out.h_count > 11'h359, 1'b1)
    wr(REG_BURST_CNT, 8'h02);
    for (int i = 0; i < 2; i++) begin
      wr(REG_SYNC_WD, (i == 0) ? 8'h20 : 8'h1d);
      wr(REG_TIMING, (i == 0) ? 8'h85 : 8'h83);
      wr(REG_TIMING, (i == 0) ? 8'h05 : 8'h03);
      n = 0;
      mx = 0;
      repeat (858) begin
        tick(1);
        if (sync_out.vsync) begin
          if (n == 0) mx = int'(sync_out.h_count);
          n++;
        end
      end
      `CHK(n, (i == 0) ? 16 : 4)
      `CHK(mx, (i == 0) ? 0 : 338)
    end
    $display("timing done");
    for (int i = 0; i < 4; i++) begin
      wr(REG_SYNC_WD, {2'(i), 6'h00});
      tick(6);
      `CHK(10'(pixel_in - pixel_out), 10'(1 + i))
    end
    $display("pixel adjust done");
    end_sim();
  end
endmodule // sde_control_regs_tb
